// ==== dmc_map.svh ====
// Purpose: register offsets, field positions and reset values of the DMA controller
// Assumes: five register-select lines, byte-wide register port
// Notes:   definitions only
`ifndef DMC_MAP_SVH
`define DMC_MAP_SVH

// ****************************************
// register indices
// ****************************************
`define DMC_OFS_ADDR_HI  2'h0
`define DMC_OFS_ADDR_LO  2'h1
`define DMC_OFS_CNT_HI   2'h2
`define DMC_OFS_CNT_LO   2'h3
`define DMC_REG_CHCTL0   5'h10
`define DMC_REG_CHCTL3   5'h13
`define DMC_REG_PRIO     5'h14
`define DMC_REG_IRQCTL   5'h15
`define DMC_REG_CHAIN    5'h16

// ****************************************
// field positions
// ****************************************
`define DMC_CC_DIR       0
`define DMC_CC_MODE_LO   1
`define DMC_CC_MODE_HI   2
`define DMC_CC_DOWN      3
`define DMC_CC_BUSY      6
`define DMC_CC_DONE      7
`define DMC_PRIO_ROTATE  7
`define DMC_IRQ_FLAG     7
`define DMC_CHAIN_EN     0
`define DMC_CHAIN_CH_LO  1
`define DMC_CHAIN_CH_HI  2
`define DMC_CHAIN_TWO    3

// ****************************************
// mode codes and reset values
// ****************************************
`define DMC_MODE_HALT    2'h0
`define DMC_MODE_STR     2'h1
`define DMC_MODE_BURST   2'h2
`define DMC_CTL_RESET    8'h00
`define DMC_FIFO_DEPTH   4

`endif

// ==== dmc_pkg.sv ====
// Purpose: shared types of the DMA controller
// Assumes: nothing
// Notes:   constants live in dmc_map.svh
package dmc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_XFER, ST_HOLD} dmc_state_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] data;
  } dmc_wr_t;

  typedef struct packed {
    logic       cs_n;
    logic       rw;
    logic [4:0] addr;
    logic [7:0] data;
    logic [3:0] req;
    logic       grant;
  } dmc_pins_t;
endpackage : dmc_pkg

// ==== dmc_chan_if.sv ====
// Purpose: carrier between the engine and one channel register pair
// Assumes: one clock
// Notes:   ctrl side drives writes and steps, chan side returns contents
`timescale 1ns/1ps
interface dmc_chan_if;
  logic        wr_en;
  logic [1:0]  wr_sel;
  logic [7:0]  wr_data;
  logic        step;
  logic        down;
  logic        chain_en;
  logic [15:0] chain_addr;
  logic [15:0] chain_cnt;
  logic [15:0] addr;
  logic [15:0] cnt;
  modport ctrl (output wr_en, wr_sel, wr_data, step, down, chain_en, chain_addr, chain_cnt,
                input addr, cnt);
  modport chan (input wr_en, wr_sel, wr_data, step, down, chain_en, chain_addr, chain_cnt,
                output addr, cnt);
endinterface : dmc_chan_if

// ==== dmc_fifo.sv ====
// Purpose: small first-in first-out buffer with valid/ready on both sides
// Assumes: depth of at least two
// Notes:   read data come straight out of the storage flops
`timescale 1ns/1ps
module dmc_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 4
) (
  input  logic             clk_i,
  input  logic             reset_i,
  input  logic             in_valid_i,
  output logic             in_ready_o,
  input  logic [WIDTH-1:0] in_data_i,
  output logic             out_valid_o,
  input  logic             out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [CW-1:0]               cnt;
  } dmc_fifo_state_t;

  dmc_fifo_state_t state_reg;
  dmc_fifo_state_t state_next;
  logic            push;
  logic            pop;

  assign in_ready_o  = state_reg.cnt != CW'(DEPTH);
  assign out_valid_o = state_reg.cnt != '0;
  assign out_data_o  = state_reg.mem[state_reg.rp];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.mem[state_reg.wp] = in_data_i;
      state_next.wp = (state_reg.wp == PW'(DEPTH - 1)) ? '0 : state_reg.wp + PW'(1);
    end
    if (pop) begin
      state_next.rp = (state_reg.rp == PW'(DEPTH - 1)) ? '0 : state_reg.rp + PW'(1);
    end
    state_next.cnt = state_reg.cnt + CW'(push) - CW'(pop);
    if (reset_i) begin
      state_next.wp  = '0;
      state_next.rp  = '0;
      state_next.cnt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    state_reg <= state_next;
  end
endmodule : dmc_fifo

// ==== dmc_channel.sv ====
// Purpose: address and byte count of one channel
// Assumes: writes and steps never coincide
// Notes:   contents survive reset on purpose
`timescale 1ns/1ps
`include "dmc_map.svh"
module dmc_channel (
  input logic   clk_i,
  dmc_chan_if.chan bus
);
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] cnt;
  } dmc_chan_state_t;

  dmc_chan_state_t state_reg;
  dmc_chan_state_t state_next;

  assign bus.addr = state_reg.addr;
  assign bus.cnt  = state_reg.cnt;

  always_comb begin
    state_next = state_reg;
    if (bus.wr_en) begin
      case (bus.wr_sel)
        `DMC_OFS_ADDR_HI: state_next.addr[15:8] = bus.wr_data;
        `DMC_OFS_ADDR_LO: state_next.addr[7:0]  = bus.wr_data;
        `DMC_OFS_CNT_HI:  state_next.cnt[15:8]  = bus.wr_data;
        default:          state_next.cnt[7:0]   = bus.wr_data;
      endcase
    end else if (bus.step) begin
      // one byte done: count down, address in the chosen direction
      state_next.cnt  = state_reg.cnt - 16'h0001;                       // [RULE27]
      state_next.addr = bus.down ? state_reg.addr - 16'h0001
                                 : state_reg.addr + 16'h0001;           // [RULE3]
      if (bus.chain_en && state_reg.cnt == 16'h0001) begin
        state_next.addr = bus.chain_addr;                               // [RULE9]
        state_next.cnt  = bus.chain_cnt;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    state_reg <= state_next;
  end
endmodule : dmc_channel

// ==== dmc_top.sv ====
// Purpose: four-channel byte DMA controller, register port and bus engine
// Assumes: clk_i is the unstretched memory phase-2 clock
// Notes:   all input pins pass two flops; register writes queue in a small buffer
// How it works
// RULE1: fifteen registers, eight of them sixteen bits, rest byte control
// RULE2: per channel address, count, control; shared priority, interrupt, chain
// RULE3: channel control selects direction, mode and address step direction
// RULE4: each channel runs stretch steal, halt steal or halt burst
// RULE5: channel control shows read-only busy and done bits
// RULE6: priority register enables requests, picks fixed or rotating order
// RULE7: count reaching zero gives block end and enabled interrupt
// RULE8: interrupt enables and the interrupt flag live in one register
// RULE9: chaining reloads chosen channel from channel 3 at zero count
// RULE10: winning request raises bus request; on grant acknowledge and move byte
// RULE11: while owning bus drive address, read/write and a strobe
// RULE12: reset clears all but address and count registers
// RULE13: software programs a channel before enabling its request
// RULE14: stretch steal drops stretch request, waits grant, one byte
// RULE15: the system floats the processor bus off the grant
// RULE16: halt steal drops halt request, grant is bus-available, one byte
// RULE17: halt burst keeps processor halted until the count is zero
// RULE18: data drivers float except on processor register reads
// RULE19: select/ack-B drives only in DMA, four-channel mode
// RULE20: the processor qualifies chip select with valid memory access
// RULE21: register access uses five address lines, read/write, chip select
// RULE22: low address lines select registers, output the address in DMA
// RULE23: read/write in DMA follows bit 0 of channel control
// RULE24: serviced channel is encoded on ack-B high bit and ack-A low
// RULE25: interrupt/end line goes low during the final byte
// RULE26: requests sampled while idle, not again until the transfer ends
// RULE27: each byte counts down by one and steps the address
`timescale 1ns/1ps
`include "dmc_map.svh"
module dmc_top #(
  parameter int FIFO_DEPTH = `DMC_FIFO_DEPTH
) (
  input  logic        clk_i,
  input  logic        reset_i,
  input  logic [7:0]  data_i,
  output logic [7:0]  data_o,
  output logic        data_oe_o,
  input  logic [4:0]  addr_lo_i,
  output logic [15:0] addr_o,
  output logic        addr_oe_o,
  input  logic        rw_i,
  output logic        rw_o,
  output logic        rw_oe_o,
  input  logic        select_or_ack_b_i,
  output logic        select_or_ack_b_o,
  output logic        select_or_ack_b_oe_o,
  output logic        ack_a_out_o,
  output logic        transfer_strobe_n_o,
  input  logic [3:0]  channel_request_in_i,
  output logic        irq_or_block_end_n_o,
  output logic        stretch_request_n_o,
  output logic        halt_request_n_o,
  input  logic        bus_grant_in_i,
  output logic        reg_write_ready_o
);
  import dmc_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    dmc_pins_t       s1;
    dmc_pins_t       s2;
    dmc_state_t      st;
    logic [1:0]      sel;
    logic [1:0]      last;
    logic [3:0][3:0] ctl;
    logic [3:0]      done;
    logic [7:0]      prio;
    logic [3:0]      ien;
    logic [7:0]      chain;
    logic            sel_prev;
    logic [7:0]      dout;
  } dmc_top_state_t;

  dmc_top_state_t  state_reg;
  dmc_top_state_t  state_next;

  dmc_chan_if      ch_if[4] ();
  logic [3:0][15:0] ch_addr;
  logic [3:0][15:0] ch_cnt;
  logic [3:0]      wr_v;
  logic [3:0]      step_v;
  logic [3:0]      busy;
  logic [7:0]      wr_data;
  logic [1:0]      wr_sel;

  logic            bus_own;
  logic            sel_now;
  logic            rd;
  logic            wr_start;
  logic            last_byte;
  logic [1:0]      mode;
  logic            irq_flag;
  logic            two_ch;
  logic            fifo_ready;
  logic            fifo_valid;
  logic            pop_ready;
  logic [$bits(dmc_wr_t)-1:0] fifo_out;
  dmc_wr_t         wq;

  // ****************************************
  // channel registers
  // ****************************************
  for (genvar i = 0; i < 4; i++) begin : g_ch
    assign ch_if[i].wr_en      = wr_v[i];
    assign ch_if[i].wr_sel     = wr_sel;
    assign ch_if[i].wr_data    = wr_data;
    assign ch_if[i].step       = step_v[i];
    assign ch_if[i].down       = state_reg.ctl[i][`DMC_CC_DOWN];
    assign ch_if[i].chain_en   = state_reg.chain[`DMC_CHAIN_EN] &&
                                 state_reg.chain[`DMC_CHAIN_CH_HI:`DMC_CHAIN_CH_LO] == 2'(i);
    assign ch_if[i].chain_addr = ch_addr[3];
    assign ch_if[i].chain_cnt  = ch_cnt[3];
    assign ch_addr[i]          = ch_if[i].addr;
    assign ch_cnt[i]           = ch_if[i].cnt;
    assign busy[i]             = state_reg.st != ST_IDLE && state_reg.sel == 2'(i);  // [RULE5]
    dmc_channel u_ch (
      .clk_i (clk_i),
      .bus   (ch_if[i])
    );
  end

  // ****************************************
  // register write queue
  // ****************************************
  // writes wait here while a byte cycle owns the count/address registers
  dmc_fifo #(
    .WIDTH ($bits(dmc_wr_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (wr_start),
    .in_ready_o  (fifo_ready),
    .in_data_i   ({state_reg.s2.addr, state_reg.s2.data}),
    .out_valid_o (fifo_valid),
    .out_ready_i (pop_ready),
    .out_data_o  (fifo_out)
  );

  assign wq                = dmc_wr_t'(fifo_out);
  assign reg_write_ready_o = fifo_ready;
  assign pop_ready         = state_reg.st != ST_XFER;
  assign wr_data           = wq.data;
  assign wr_sel            = wq.addr[1:0];

  // ****************************************
  // decode
  // ****************************************
  assign bus_own   = state_reg.st == ST_XFER;
  assign two_ch    = state_reg.chain[`DMC_CHAIN_TWO];
  assign mode      = state_reg.ctl[state_reg.sel][`DMC_CC_MODE_HI:`DMC_CC_MODE_LO];  // [RULE4]
  assign last_byte = ch_cnt[state_reg.sel] == 16'h0001;
  assign sel_now   = !state_reg.s2.cs_n && !bus_own;                 // [RULE21]
  assign rd        = sel_now && state_reg.s2.rw;
  assign wr_start  = sel_now && !state_reg.s2.rw && !state_reg.sel_prev;
  assign irq_flag  = |(state_reg.done & state_reg.ien);              // [RULE7]

  // lowest offset from the base wins
  function automatic logic [2:0] pick(input logic [3:0] r, input logic [1:0] base);
    logic [2:0] res;
    logic [1:0] idx;
    res = 3'h0;
    for (int k = 3; k >= 0; k--) begin
      idx = base + 2'(k);
      if (r[idx]) begin
        res = {1'b1, idx};
      end
    end
    return res;
  endfunction : pick

  function automatic logic [7:0] read_mux(input dmc_top_state_t s,
                                          input logic [3:0][15:0] a,
                                          input logic [3:0][15:0] c,
                                          input logic [3:0] b,
                                          input logic f);
    logic [7:0] v;
    v = 8'h00;
    if (!s.s2.addr[4]) begin
      case (s.s2.addr[1:0])
        `DMC_OFS_ADDR_HI: v = a[s.s2.addr[3:2]][15:8];
        `DMC_OFS_ADDR_LO: v = a[s.s2.addr[3:2]][7:0];
        `DMC_OFS_CNT_HI:  v = c[s.s2.addr[3:2]][15:8];
        default:          v = c[s.s2.addr[3:2]][7:0];
      endcase
    end else if (s.s2.addr <= `DMC_REG_CHCTL3) begin
      v = {s.done[s.s2.addr[1:0]], b[s.s2.addr[1:0]], 2'h0, s.ctl[s.s2.addr[1:0]]};  // [RULE5]
    end else if (s.s2.addr == `DMC_REG_PRIO) begin
      v = s.prio;
    end else if (s.s2.addr == `DMC_REG_IRQCTL) begin
      v = {f, 3'h0, s.ien};  // [RULE8] [RULE1]
    end else if (s.s2.addr == `DMC_REG_CHAIN) begin
      v = s.chain;
    end
    return v;
  endfunction : read_mux

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [3:0] dset;
    logic [3:0] dclr;
    logic [2:0] win;
    logic [1:0] base;
    dset       = 4'h0;
    dclr       = 4'h0;
    win        = 3'h0;
    base       = 2'h0;
    wr_v       = 4'h0;
    step_v     = 4'h0;
    state_next = state_reg;

    // pins enter through two flops
    state_next.s1.cs_n  = select_or_ack_b_oe_o ? 1'b1 : select_or_ack_b_i;  // [RULE19]
    state_next.s1.rw    = rw_i;
    state_next.s1.addr  = addr_lo_i;
    state_next.s1.data  = data_i;
    state_next.s1.req   = channel_request_in_i;
    state_next.s1.grant = bus_grant_in_i;
    state_next.s2       = state_reg.s1;
    state_next.sel_prev = sel_now;

    // processor reads; a read of channel control acknowledges done
    if (rd) begin
      state_next.dout = read_mux(state_reg, ch_addr, ch_cnt, busy, irq_flag);
      if (!state_reg.sel_prev && state_reg.s2.addr[4] &&
          state_reg.s2.addr <= `DMC_REG_CHCTL3) begin
        dclr[state_reg.s2.addr[1:0]] = 1'b1;
      end
    end

    // queued processor writes
    if (fifo_valid && pop_ready) begin
      if (!wq.addr[4]) begin
        wr_v[wq.addr[3:2]] = 1'b1;                                   // [RULE2]
      end else if (wq.addr <= `DMC_REG_CHCTL3) begin
        state_next.ctl[wq.addr[1:0]] = wq.data[3:0];                 // [RULE3]
      end else if (wq.addr == `DMC_REG_PRIO) begin
        state_next.prio = wq.data;                                   // [RULE6]
      end else if (wq.addr == `DMC_REG_IRQCTL) begin
        state_next.ien = wq.data[3:0];                               // [RULE8]
      end else if (wq.addr == `DMC_REG_CHAIN) begin
        state_next.chain = wq.data;                                  // [RULE9]
      end
    end

    // transfer engine
    case (state_reg.st)
      ST_IDLE: begin
        // requests only arbitrated here, so the strobed channel holds
        base = state_reg.prio[`DMC_PRIO_ROTATE] ? state_reg.last + 2'h1 : 2'h0;  // [RULE6]
        win  = pick(state_reg.s2.req & state_reg.prio[3:0], base);   // [RULE26]
        if (win[2]) begin
          state_next.sel = win[1:0];
          state_next.st  = ST_REQ;                                   // [RULE10]
        end
      end
      ST_REQ: begin
        if (state_reg.s2.grant) begin
          state_next.st = ST_XFER;                                   // [RULE10]
        end
      end
      ST_XFER: begin
        step_v[state_reg.sel] = 1'b1;                                // [RULE27]
        state_next.last       = state_reg.sel;
        if (last_byte) begin
          dset[state_reg.sel] = 1'b1;                                // [RULE7]
          state_next.st       = ST_IDLE;
        end else if (mode == `DMC_MODE_BURST) begin
          state_next.st = ST_HOLD;                                   // [RULE17]
        end else begin
          state_next.st = ST_IDLE;                                   // [RULE14] [RULE16]
        end
      end
      ST_HOLD: begin
        // burst keeps the processor halted between bytes
        if (state_reg.s2.req[state_reg.sel] && state_reg.s2.grant) begin
          state_next.st = ST_XFER;                                   // [RULE17]
        end
      end
      default: begin
        state_next.st = ST_IDLE;
      end
    endcase

    // a completion in the same cycle as its read keeps the flag
    state_next.done = (state_reg.done & ~dclr) | dset;

    if (reset_i) begin
      state_next.st       = ST_IDLE;                                 // [RULE12]
      state_next.sel      = 2'h0;
      state_next.last     = 2'h0;
      state_next.ctl      = '0;
      state_next.done     = 4'h0;
      state_next.prio     = `DMC_CTL_RESET;
      state_next.ien      = 4'h0;
      state_next.chain    = `DMC_CTL_RESET;
      state_next.sel_prev = 1'b0;
      state_next.dout     = 8'h00;
      state_next.s1       = '1;
      state_next.s2       = '1;
    end
  end

  always_ff @(posedge clk_i) begin
    state_reg <= state_next;
  end

  // ****************************************
  // pins
  // ****************************************
  assign data_o               = state_reg.dout;
  assign data_oe_o            = rd;                                  // [RULE18]
  assign addr_o               = ch_addr[state_reg.sel];              // [RULE22]
  assign addr_oe_o            = bus_own;                             // [RULE11]
  assign rw_o                 = state_reg.ctl[state_reg.sel][`DMC_CC_DIR];  // [RULE23]
  assign rw_oe_o              = bus_own;                             // [RULE11]
  assign transfer_strobe_n_o  = !bus_own;                            // [RULE11]
  assign ack_a_out_o          = bus_own && state_reg.sel[0];         // [RULE24]
  assign select_or_ack_b_o    = state_reg.sel[1];                    // [RULE24]
  assign select_or_ack_b_oe_o = bus_own && !two_ch;                  // [RULE19]
  // block end during the last byte, interrupt afterwards while enabled
  assign irq_or_block_end_n_o = !(irq_flag || (bus_own && last_byte));  // [RULE25]
  assign stretch_request_n_o  = !(state_reg.st == ST_REQ && mode == `DMC_MODE_STR);  // [RULE14]
  assign halt_request_n_o     = !(mode != `DMC_MODE_STR &&
                                  (state_reg.st == ST_REQ ||
                                   (mode == `DMC_MODE_BURST &&
                                    (state_reg.st == ST_HOLD ||
                                     (bus_own && !last_byte)))));    // [RULE16] [RULE17]
endmodule : dmc_top

// ==== dmc_top_checker.sv ====
// Purpose: port properties of the DMA controller
// Assumes: one clock, synchronous reset
// Notes:   bound onto dmc_top
`timescale 1ns/1ps
module dmc_top_checker #(
  parameter int FIFO_DEPTH = 4
) (
  input logic clk_i,
  input logic reset_i,
  input logic rw_i,
  input logic select_or_ack_b_i,
  input logic bus_grant_in_i,
  input logic data_oe_o,
  input logic addr_oe_o,
  input logic rw_oe_o,
  input logic select_or_ack_b_oe_o,
  input logic ack_a_out_o,
  input logic transfer_strobe_n_o,
  input logic stretch_request_n_o,
  input logic halt_request_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  chk_bus_drive: assert property (!transfer_strobe_n_o |-> addr_oe_o && rw_oe_o)
    else $error("strobe without bus drive");
  chk_drive_only_xfer: assert property (addr_oe_o |-> !transfer_strobe_n_o)
    else $error("address driven outside byte cycle");
  chk_data_float: assert property (data_oe_o |->
    transfer_strobe_n_o && $past(rw_i, 2) && !$past(select_or_ack_b_i, 2))
    else $error("data driven without register read");
  chk_grant_first: assert property (!transfer_strobe_n_o |-> $past(bus_grant_in_i, 3))
    else $error("byte cycle without grant");
  chk_one_byte: assert property (!transfer_strobe_n_o |=> transfer_strobe_n_o)
    else $error("strobe longer than one cycle");
  chk_ack_idle: assert property (transfer_strobe_n_o |->
    !ack_a_out_o && !select_or_ack_b_oe_o)
    else $error("acknowledge outside byte cycle");
  chk_halt_release: assert property ($rose(halt_request_n_o) |-> !transfer_strobe_n_o)
    else $error("halt released without byte");
  chk_stretch_hold: assert property (!stretch_request_n_o |=>
    !stretch_request_n_o || !transfer_strobe_n_o)
    else $error("stretch request dropped early");
  chk_one_request: assert property (stretch_request_n_o || halt_request_n_o)
    else $error("both requests low");
  cov_stretch: cover property (!stretch_request_n_o ##[1:20] !transfer_strobe_n_o);
  cov_burst: cover property (!halt_request_n_o && !transfer_strobe_n_o);
  cov_read: cover property (data_oe_o);
endmodule : dmc_top_checker

bind dmc_top dmc_top_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.clk_i(clk_i), .reset_i(reset_i),
  .rw_i(rw_i), .select_or_ack_b_i(select_or_ack_b_i), .bus_grant_in_i(bus_grant_in_i),
  .data_oe_o(data_oe_o), .addr_oe_o(addr_oe_o), .rw_oe_o(rw_oe_o),
  .select_or_ack_b_oe_o(select_or_ack_b_oe_o), .ack_a_out_o(ack_a_out_o),
  .transfer_strobe_n_o(transfer_strobe_n_o), .stretch_request_n_o(stretch_request_n_o),
  .halt_request_n_o(halt_request_n_o));

// ==== dmc_partner.sv ====
// Purpose: processor grant and peripheral request model
// Assumes: one active channel at a time
// Notes:   requests drop early since the design sees them two cycles late
`timescale 1ns/1ps
module dmc_partner (
  input  logic        clk_i,
  input  logic        go_i,
  input  logic        burst_i,
  input  logic [1:0]  ch_i,
  input  logic [15:0] nbytes_i,
  input  logic [3:0]  gdelay_i,
  input  logic        stretch_request_n_i,
  input  logic        halt_request_n_i,
  input  logic        transfer_strobe_n_i,
  output logic [3:0]  req_o,
  output logic        grant_o
);
  logic [15:0] left;
  logic        pend;
  logic [3:0]  wcnt;
  logic        rq;
  logic        stb;
  assign rq    = !stretch_request_n_i || !halt_request_n_i;
  assign stb   = !transfer_strobe_n_i;
  assign req_o = pend ? (4'h1 << ch_i) : 4'h0;
  initial begin
    left = 16'h0;
    pend = 1'b0;
    wcnt = 4'h0;
    grant_o = 1'b0;
  end
  always @(posedge clk_i) begin
    if (go_i) begin
      left <= nbytes_i;
      pend <= 1'b1;
    end else if (stb) begin
      left <= left - 16'h1;
      if (burst_i) begin
        if (left == 16'h2) pend <= 1'b0;
      end else begin
        pend <= (left != 16'h1);
      end
    end else if (rq && (!burst_i || left == 16'h1)) begin
      pend <= 1'b0;
    end
    // slow grant via gdelay_i; held until the byte is strobed
    if (rq) begin
      if (wcnt != 4'hF) wcnt <= wcnt + 4'h1;
      grant_o <= (wcnt >= gdelay_i);
    end else if (stb) begin
      wcnt <= 4'h0;
      grant_o <= 1'b0;
    end
  end
endmodule : dmc_partner

// ==== tb_dmc_top.sv ====
// Purpose: self-checking bench of the DMA controller
// Assumes: register port protocol of the block
// Notes:   shared pins resolved here from all enables
`timescale 1ns/1ps
module tb_dmc_top;
  logic clk_i, reset_i, rw_drv, cs_drv, go, burst;
  logic [7:0] d_drv, data_o;
  logic [4:0] a_drv;
  logic [1:0] ch;
  logic [15:0] nbytes, addr_o;
  logic [3:0] gdelay, req;
  logic data_oe_o, addr_oe_o, rw_o, rw_oe_o, sb_o, sb_oe, ack_a, stb_n, irq_n, str_n, halt_n;
  logic grant, wready;
  int failures, checks;
  logic [20:0] seen[$];

  dmc_top dut (.clk_i(clk_i), .reset_i(reset_i), .data_i(data_oe_o ? data_o : d_drv),
    .data_o(data_o), .data_oe_o(data_oe_o), .addr_lo_i(addr_oe_o ? addr_o[4:0] : a_drv),
    .addr_o(addr_o), .addr_oe_o(addr_oe_o), .rw_i(rw_oe_o ? rw_o : rw_drv), .rw_o(rw_o),
    .rw_oe_o(rw_oe_o), .select_or_ack_b_i(sb_oe ? sb_o : cs_drv), .select_or_ack_b_o(sb_o),
    .select_or_ack_b_oe_o(sb_oe), .ack_a_out_o(ack_a), .transfer_strobe_n_o(stb_n),
    .channel_request_in_i(req), .irq_or_block_end_n_o(irq_n), .stretch_request_n_o(str_n),
    .halt_request_n_o(halt_n), .bus_grant_in_i(grant), .reg_write_ready_o(wready));
  dmc_partner far (.clk_i(clk_i), .go_i(go), .burst_i(burst), .ch_i(ch), .nbytes_i(nbytes),
    .gdelay_i(gdelay), .stretch_request_n_i(str_n), .halt_request_n_i(halt_n),
    .transfer_strobe_n_i(stb_n), .req_o(req), .grant_o(grant));

  // ****************************************
  // tasks
  // ****************************************
  task automatic report_and_stop;
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cs_drv <= 1'b0;
    rw_drv <= 1'b0;
    a_drv <= a;
    d_drv <= d;
    repeat (3) @(posedge clk_i);
    cs_drv <= 1'b1;
    rw_drv <= 1'b1;
    d_drv <= ~d;
    repeat (3) @(posedge clk_i);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    cs_drv <= 1'b0;
    rw_drv <= 1'b1;
    a_drv <= a;
    repeat (3) @(posedge clk_i);
    #1;
    check({data_oe_o, data_o}, {1'b1, exp});
    @(posedge clk_i);
    cs_drv <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask : rd

  // one block on channel c; alo/clo are address and count low bytes afterwards
  task automatic run(input logic [1:0] c, input logic [15:0] a, input logic [15:0] n,
                     input logic [7:0] ctl, input logic [7:0] alo, input logic [7:0] clo);
    logic [15:0] ea;
    int k;
    wr({1'b0, c, 2'h0}, a[15:8]);
    wr({1'b0, c, 2'h1}, a[7:0]);
    wr({1'b0, c, 2'h2}, n[15:8]);
    wr({1'b0, c, 2'h3}, n[7:0]);
    wr({3'b100, c}, ctl);
    wr(5'h14, 8'h01 << c);
    @(posedge clk_i);
    ch <= c;
    nbytes <= n;
    burst <= (ctl[2:1] == 2'h2);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    k = 0;
    while (seen.size() < n && k < 2000) begin
      @(posedge clk_i);
      k++;
    end
    repeat (30) @(posedge clk_i);
    check(seen.size(), n);
    ea = a;
    for (k = 0; k < n; k++) begin
      check(seen[k], {1'b1, k != n - 1, c, ctl[0], ea});
      ea = ctl[3] ? ea - 16'h1 : ea + 16'h1;
    end
    seen.delete();
    check(irq_n, 1'b0);
    rd(5'h15, 8'h8F);
    rd({3'b100, c}, ctl | 8'h80);
    check(irq_n, 1'b1);
    rd({1'b0, c, 2'h1}, alo);
    rd({1'b0, c, 2'h3}, clo);
    wr(5'h14, 8'h00);
  endtask : run

  // ****************************************
  // clock, monitor, sequence, watchdog
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (!reset_i && stb_n === 1'b0) seen.push_back({sb_oe, irq_n, sb_o, ack_a, rw_o, addr_o});
  end

  initial begin
    reset_i = 1'b1;
    cs_drv = 1'b1;
    rw_drv = 1'b1;
    a_drv = 5'h00;
    d_drv = 8'h00;
    go = 1'b0;
    burst = 1'b0;
    ch = 2'h0;
    nbytes = 16'h0000;
    gdelay = 4'h0;
    failures = 0;
    checks = 0;
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    check({irq_n, str_n, halt_n, stb_n, wready}, 5'h1F);
    for (int k = 0; k < 8; k++) rd({2'b10, k[2:0]}, 8'h00);
    wr(5'h15, 8'h0F);
    run(2'h0, 16'h1234, 16'h0002, 8'h03, 8'h36, 8'h00);
    gdelay <= 4'h5;
    run(2'h1, 16'h2000, 16'h0001, 8'h00, 8'h01, 8'h00);
    wr(5'h0C, 8'h0A);
    wr(5'h0D, 8'hBC);
    wr(5'h0E, 8'h00);
    wr(5'h0F, 8'h05);
    wr(5'h16, 8'h05);
    run(2'h2, 16'h3000, 16'h0002, 8'h09, 8'hBC, 8'h05);
    wr(5'h16, 8'h00);
    gdelay <= 4'h0;
    run(2'h3, 16'h0100, 16'h0003, 8'h0C, 8'hFD, 8'h00);
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    report_and_stop();
  end
endmodule : tb_dmc_top
